/* File: verilog/occ_top.sv */
/*
 * oscillator and clock gate control: APB slave with the clock gate
 * register, the key-protected oscillator control register, stable flags
 * and an interrupt status/mask pair.
 * assumes an APB master on pclk and raw, asynchronous ready levels from
 * the three oscillator cells; the consumers of the enables sit on pclk.
 */
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps

module occ_top
	import occ_pkg::*;
#(
	parameter int FILTER_CYCLES = OCC_FILTER_CYCLES
) (
	input wire logic pclk, // bus clock, 50 MHz
	input wire logic presetn, // async reset, active low
	input wire logic ce, // clock enable, freezes state when low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [OCC_ADDR_W-1:0] paddr, // apb byte address
	input wire logic [OCC_DATA_W-1:0] pwdata, // apb write data
	input wire logic [OCC_STRB_W-1:0] pstrb, // apb byte strobes
	output logic [OCC_DATA_W-1:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address
	input wire occ_osc_s osc_ready_raw, // raw ready levels from the cells
	output occ_osc_s osc_on, // oscillator enables
	output occ_osc_s osc_stable, // sticky stable flags
	output logic afe_ctrl_clock_off, // stop the AFE control clock
	output logic [OCC_REG_W-1:0] clock_gate_enables, // whole gate register
	output logic osc_unlocked, // key protection open
	output logic irq // level interrupt
);

	localparam logic [OCC_DATA_W-1:0] DATA_ZERO = '0;
	localparam logic [OCC_REG_W-1:0] REG_ZERO = '0;

	// field geometry; only the low halfword, mostly lane 0, carries state
	localparam int LANE_W = 8;
	localparam int LANE_LO = 0;
	localparam int LANE_HI = 1;
	localparam int EN_W = 3;
	localparam int EN_MSB = OCC_XTAL_EN_BIT;
	localparam int EN_LSB = OCC_LO_EN_BIT;
	localparam int REG_PAD_W = OCC_DATA_W - OCC_REG_W;
	localparam int IRQ_PAD_W = OCC_DATA_W - OCC_IRQ_W;
	localparam logic [1:0] KEY_LANES = 2'h3;
	localparam logic [REG_PAD_W-1:0] REG_PAD = '0;
	localparam logic [IRQ_PAD_W-1:0] IRQ_PAD = '0;

	// decode and access qualification
	occ_dec_s dec;
	logic mapped;
	logic acc_phase;
	logic wr_fire;
	logic rd_capture;
	logic cap_done;

	assign dec.sel_gate = (paddr == OCC_OFF_CLK_GATE);
	assign dec.sel_key = (paddr == OCC_OFF_UNLOCK_KEY);
	assign dec.sel_osc = (paddr == OCC_OFF_OSC_CTRL);
	assign dec.sel_stat = (paddr == OCC_OFF_IRQ_STATUS);
	assign dec.sel_mask = (paddr == OCC_OFF_IRQ_MASK);
	assign mapped = |dec;

	// answer one cycle after the address has been sampled
	assign acc_phase = psel && penable;
	assign pready = ce && acc_phase && cap_done;
	assign wr_fire = pready && pwrite && mapped;
	assign rd_capture = ce && psel && !cap_done;

	// byte-lane merge of the low halfword
	logic [OCC_REG_W-1:0] lane_mask;
	logic [OCC_REG_W-1:0] wdata16;

	assign lane_mask = {{LANE_W{pstrb[LANE_HI]}}, {LANE_W{pstrb[LANE_LO]}}};
	assign wdata16 = pwdata[OCC_REG_W-1:0];

	// register state
	logic [OCC_REG_W-1:0] key_reg;
	logic [2:0] osc_en;
	logic [OCC_IRQ_W-1:0] irq_status;
	logic [OCC_IRQ_W-1:0] irq_mask;

	// clock gate register
	logic gate_we;
	logic [OCC_REG_W-1:0] gate_wmask;
	logic [OCC_REG_W-1:0] next_gate;

	assign gate_we = wr_fire && dec.sel_gate;
	// software keeps reserved bits at reset values; hardware stores bits 9:0 as written and drops writes to bits 15:10
	assign gate_wmask = lane_mask & OCC_CLK_GATE_WMASK;
	// init bits 3 and 0 are plain storage that software sets at start-up
	assign next_gate = (clock_gate_enables & ~gate_wmask) | (wdata16 & gate_wmask);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_gate_enables <= OCC_CLK_GATE_RST;
		end else if (ce && gate_we) begin
			clock_gate_enables <= next_gate;
		end
	end

	// the clock itself is gated downstream; this is its stop request
	assign afe_ctrl_clock_off = clock_gate_enables[OCC_AFE_OFF_BIT];

	// key register and protection state
	logic key_we;
	logic key_full_write;
	logic key_match;
	logic osc_we;
	logic other_we;
	logic next_unlocked;
	logic locked_reject;

	assign key_we = wr_fire && dec.sel_key;
	assign key_full_write = key_we && (pstrb[LANE_HI:LANE_LO] == KEY_LANES);
	assign key_match = key_full_write && (wdata16 == OCC_UNLOCK_VALUE);
	assign osc_we = wr_fire && dec.sel_osc;
	// any other write closes the lock, a wrong key or an unmapped address too,
	// so a stray access cannot leave the control register open
	assign other_we = pready && pwrite && !dec.sel_osc && !key_match;
	assign locked_reject = osc_we && !osc_unlocked;

	// one unlock covers exactly one control write, then relocks
	assign next_unlocked = key_match ? 1'b1 :
		((other_we || osc_we) ? 1'b0 : osc_unlocked);

	// protection state follows every completed write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_unlocked <= 1'b0;
		end else if (ce) begin
			osc_unlocked <= next_unlocked;
		end
	end

	// key storage reads back as written; only a full, matching write unlocks
	logic [OCC_REG_W-1:0] next_key;

	assign next_key = (key_reg & ~lane_mask) | (wdata16 & lane_mask);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key_reg <= OCC_KEY_RST;
		end else if (ce && key_we) begin
			key_reg <= next_key;
		end
	end

	// oscillator enables, writable only while unlocked
	logic osc_take;
	logic [2:0] osc_lane;
	logic [2:0] next_osc_en;

	assign osc_take = osc_we && osc_unlocked;
	// a write with lane 0 off leaves the enables as they are
	assign osc_lane = {EN_W{pstrb[LANE_LO]}};
	assign next_osc_en = (osc_en & ~osc_lane) | (pwdata[EN_MSB:EN_LSB] & osc_lane);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_en <= OCC_OSC_EN_RST;
		end else if (ce && osc_take) begin
			osc_en <= next_osc_en;
		end
	end

	// enable fields to the analog cells
	assign osc_on.xtal = osc_en[OCC_XTAL_EN_BIT];
	assign osc_on.hi = osc_en[OCC_HI_EN_BIT];
	assign osc_on.lo = osc_en[OCC_LO_EN_BIT];

	// stable tracking, one tracker per oscillator
	occ_osc_s stable_evt;

	// crystal oscillator
	occ_osc_tracker #(
		.FILTER_CYCLES(FILTER_CYCLES)
	) u_track_xtal (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.osc_on(osc_on.xtal),
		.ready_async(osc_ready_raw.xtal),
		.stable_flag(osc_stable.xtal),
		.stable_event(stable_evt.xtal)
	);

	// internal fast oscillator
	occ_osc_tracker #(
		.FILTER_CYCLES(FILTER_CYCLES)
	) u_track_hi (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.osc_on(osc_on.hi),
		.ready_async(osc_ready_raw.hi),
		.stable_flag(osc_stable.hi),
		.stable_event(stable_evt.hi)
	);

	// internal slow oscillator
	occ_osc_tracker #(
		.FILTER_CYCLES(FILTER_CYCLES)
	) u_track_lo (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.osc_on(osc_on.lo),
		.ready_async(osc_ready_raw.lo),
		.stable_flag(osc_stable.lo),
		.stable_event(stable_evt.lo)
	);

	// interrupt events: stable flags rising and rejected writes
	logic [OCC_IRQ_W-1:0] irq_set;
	logic [OCC_IRQ_W-1:0] irq_clr;
	logic [OCC_IRQ_W-1:0] next_status;
	logic mask_we;

	assign irq_set[OCC_IRQ_XTAL] = stable_evt.xtal;
	assign irq_set[OCC_IRQ_HI] = stable_evt.hi;
	assign irq_set[OCC_IRQ_LO] = stable_evt.lo;
	assign irq_set[OCC_IRQ_LOCKED] = locked_reject;

	// write one to clear, low lane only; a set in the same cycle wins
	logic [OCC_IRQ_W-1:0] irq_wbits;
	logic stat_we;

	assign irq_wbits = pwdata[OCC_IRQ_W-1:0];
	assign stat_we = wr_fire && dec.sel_stat && pstrb[LANE_LO];
	assign irq_clr = stat_we ? irq_wbits : OCC_IRQ_RST;
	assign next_status = (irq_status & ~irq_clr) | irq_set;
	assign mask_we = wr_fire && dec.sel_mask && pstrb[LANE_LO];

	// sticky status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= OCC_IRQ_RST;
		end else if (ce) begin
			irq_status <= next_status;
		end
	end

	// mask, same layout as status; a one lets the event through
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask <= OCC_IRQ_RST;
		end else if (ce && mask_we) begin
			irq_mask <= irq_wbits;
		end
	end

	// level output, registered so it holds no decode glitches
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else if (ce) begin
			irq <= |(next_status & irq_mask);
		end
	end

	// read view of the control register with its status flags
	logic [OCC_REG_W-1:0] osc_view;

	always_comb begin
		osc_view = REG_ZERO;
		osc_view[OCC_XTAL_OK_BIT] = osc_stable.xtal;
		osc_view[OCC_HI_OK_BIT] = osc_stable.hi;
		osc_view[OCC_LO_OK_BIT] = osc_stable.lo;
		osc_view[EN_MSB:EN_LSB] = osc_en;
	end

	// read words, each padded with zeros to the bus width
	logic [OCC_DATA_W-1:0] rd_gate;
	logic [OCC_DATA_W-1:0] rd_key;
	logic [OCC_DATA_W-1:0] rd_osc;
	logic [OCC_DATA_W-1:0] rd_stat;
	logic [OCC_DATA_W-1:0] rd_mask;

	assign rd_gate = {REG_PAD, clock_gate_enables};
	assign rd_key = {REG_PAD, key_reg};
	assign rd_osc = {REG_PAD, osc_view};
	assign rd_stat = {IRQ_PAD, irq_status};
	assign rd_mask = {IRQ_PAD, irq_mask};

	// read mux; unmapped addresses read zero
	logic [OCC_DATA_W-1:0] rd_mux;

	assign rd_mux = dec.sel_gate ? rd_gate :
		dec.sel_key ? rd_key :
		dec.sel_osc ? rd_osc :
		dec.sel_stat ? rd_stat :
		dec.sel_mask ? rd_mask :
		DATA_ZERO;

	// read data and error look at the address in the first selected cycle, writes decode it in the access phase;
	// capturing early lets pready rise in the access phase with no wait state
	logic next_cap;
	logic [OCC_DATA_W-1:0] next_prdata;
	logic next_slverr;

	assign next_cap = pready ? 1'b0 : (rd_capture ? 1'b1 : cap_done);
	// a write answers with zero so stale read data never rides along
	assign next_prdata = pwrite ? DATA_ZERO : rd_mux;
	// unmapped reads return zero together with the error flag
	assign next_slverr = !mapped;

	// capture flag, cleared as the answer is taken
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_done <= 1'b0;
		end else if (ce) begin
			cap_done <= next_cap;
		end
	end

	// read data and error, held until the next capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= DATA_ZERO;
			pslverr <= 1'b0;
		end else if (rd_capture) begin
			prdata <= next_prdata;
			pslverr <= next_slverr;
		end
	end

	// software keeps crystal and fast enables set before a system reset request;
	// this block only exposes them, it does not enforce the ordering

endmodule

/* File: common/occ_pkg.sv */
/*
 * shared constants and types of the oscillator and clock gate control block.
 * assumes a 32-bit APB master and a 50 MHz pclk; the analog side delivers
 * raw oscillator ready levels that are asynchronous to pclk.
 */
package occ_pkg;

	// bus geometry
	localparam int OCC_DATA_W = 32;
	localparam int OCC_ADDR_W = 32;
	localparam int OCC_REG_W = 16;
	localparam int OCC_STRB_W = 4;

	// register byte addresses
	localparam logic [31:0] OCC_OFF_CLK_GATE = 32'h0000_0410;
	localparam logic [31:0] OCC_OFF_UNLOCK_KEY = 32'h0000_0A0C;
	localparam logic [31:0] OCC_OFF_OSC_CTRL = 32'h0000_0A10;
	localparam logic [31:0] OCC_OFF_IRQ_STATUS = 32'h0000_0A20;
	localparam logic [31:0] OCC_OFF_IRQ_MASK = 32'h0000_0A24;

	// reset values and writable masks
	localparam logic [15:0] OCC_CLK_GATE_RST = 16'h01C0;
	localparam logic [15:0] OCC_CLK_GATE_WMASK = 16'h03FF;
	localparam logic [15:0] OCC_KEY_RST = 16'h0000;
	localparam logic [15:0] OCC_UNLOCK_VALUE = 16'hCB14;
	localparam logic [2:0] OCC_OSC_EN_RST = 3'h3;

	// field positions
	localparam int OCC_AFE_OFF_BIT = 5;
	localparam int OCC_INIT_BIT_A = 3;
	localparam int OCC_INIT_BIT_B = 0;
	localparam int OCC_XTAL_EN_BIT = 2;
	localparam int OCC_HI_EN_BIT = 1;
	localparam int OCC_LO_EN_BIT = 0;
	localparam int OCC_XTAL_OK_BIT = 10;
	localparam int OCC_HI_OK_BIT = 9;
	localparam int OCC_LO_OK_BIT = 8;

	// interrupt status layout
	localparam int OCC_IRQ_W = 4;
	localparam int OCC_IRQ_XTAL = 0;
	localparam int OCC_IRQ_HI = 1;
	localparam int OCC_IRQ_LO = 2;
	localparam int OCC_IRQ_LOCKED = 3;
	localparam logic [3:0] OCC_IRQ_RST = 4'h0;

	// ready level must hold this many pclk cycles before it counts
	localparam int OCC_FILTER_CYCLES = 4;

	// one bit per oscillator, used for enables, ready levels and flags
	typedef struct packed {
		logic xtal;
		logic hi;
		logic lo;
	} occ_osc_s;

	// decoded apb request
	typedef struct packed {
		logic sel_gate;
		logic sel_key;
		logic sel_osc;
		logic sel_stat;
		logic sel_mask;
	} occ_dec_s;

endpackage

/* File: verilog/occ_osc_tracker.sv */
/*
 * stable-flag tracker for one oscillator.
 * assumes ready_async comes straight from the analog cell, unsynchronised,
 * and that osc_on is a pclk-domain register.
 */
`timescale 1ns/1ps
module occ_osc_tracker
	import occ_pkg::*;
#(
	parameter int FILTER_CYCLES = OCC_FILTER_CYCLES
) (
	input wire logic pclk, // bus clock
	input wire logic presetn, // async reset, active low
	input wire logic ce, // clock enable
	input wire logic osc_on, // oscillator enabled
	input wire logic ready_async, // raw ready level from the cell
	output logic stable_flag, // sticky stable indication
	output logic stable_event // one-cycle pulse when flag sets
);

	localparam int CNT_W = $clog2(FILTER_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FILTER_CYCLES - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = '0;
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	logic ready_meta;
	logic ready_sync;
	logic [CNT_W-1:0] hold_cnt;
	logic next_flag;
	logic [CNT_W-1:0] next_cnt;

	// two flops; only the second is looked at
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_meta <= 1'b0;
			ready_sync <= 1'b0;
		end else if (ce) begin
			ready_meta <= ready_async;
			ready_sync <= ready_meta;
		end
	end

	// filter: ready must hold for a few cycles before the flag sets
	assign stable_event = osc_on && !stable_flag && ready_sync && (hold_cnt == CNT_LAST);

	// once set the flag ignores ready; only disabling clears it
	assign next_flag = osc_on && (stable_flag || stable_event);
	assign next_cnt = (!osc_on || stable_flag || !ready_sync) ? CNT_ZERO :
		(stable_event ? CNT_ZERO : hold_cnt + CNT_ONE);

	// flag and filter state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stable_flag <= 1'b0;
			hold_cnt <= CNT_ZERO;
		end else if (ce) begin
			stable_flag <= next_flag;
			hold_cnt <= next_cnt;
		end
	end

endmodule

/* File: verification/occ_top_monitor.sv */
/*
 * concurrent checks on the occ_top ports, bound into every occ_top.
 * assumes one pclk domain, presetn async active low, default filter depth.
 */
`timescale 1ns/1ps
module occ_top_monitor
	import occ_pkg::*;
#(
	parameter int FILTER_CYCLES = OCC_FILTER_CYCLES
) (
	input wire logic pclk, // clock
	input wire logic presetn, // reset, active low
	input wire logic ce, // clock enable
	input wire logic psel, // select
	input wire logic penable, // access phase
	input wire logic pwrite, // direction
	input wire logic [OCC_ADDR_W-1:0] paddr, // address
	input wire logic [OCC_DATA_W-1:0] pwdata, // write data
	input wire logic [OCC_STRB_W-1:0] pstrb, // strobes
	input wire logic [OCC_DATA_W-1:0] prdata, // read data
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire occ_osc_s osc_ready_raw, // raw ready levels
	input wire occ_osc_s osc_on, // enables
	input wire occ_osc_s osc_stable, // stable flags
	input wire logic afe_ctrl_clock_off, // afe clock stop
	input wire logic [OCC_REG_W-1:0] clock_gate_enables, // gate register
	input wire logic osc_unlocked, // key open
	input wire logic irq // interrupt
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// completed writes, decoded per register
	wire wr = psel & penable & pready & pwrite;
	wire wr_gate = wr & (paddr == OCC_OFF_CLK_GATE) & (pstrb[1:0] == 2'b11);
	wire wr_key = wr & (paddr == OCC_OFF_UNLOCK_KEY);
	wire wr_osc = wr & (paddr == OCC_OFF_OSC_CTRL) & pstrb[0];
	wire wr_other = wr & (paddr != OCC_OFF_OSC_CTRL) & (paddr != OCC_OFF_UNLOCK_KEY);
	wire key_ok = wr_key & (pstrb[1:0] == 2'b11) & (pwdata[15:0] == OCC_UNLOCK_VALUE);

	AST_AFE_FOLLOWS_GATE: assert property (
		afe_ctrl_clock_off == clock_gate_enables[OCC_AFE_OFF_BIT]) else $error("afe stop bit off");
	AST_AFE_HOLDS: assert property (!(wr && paddr == OCC_OFF_CLK_GATE) |=>
		$stable(afe_ctrl_clock_off)) else $error("afe stop bit moved without a write");
	AST_GATE_STORES: assert property (wr_gate |=>
		clock_gate_enables == {6'h00, $past(pwdata[9:0])}) else $error("gate write lost");
	AST_KEY_OPENS: assert property (key_ok |=> osc_unlocked)
		else $error("key did not unlock");
	AST_LOCKED_IGNORED: assert property (!osc_unlocked && wr_osc |=> $stable(osc_on))
		else $error("locked write changed enables");
	AST_UNLOCKED_TAKES: assert property (osc_unlocked && wr_osc |=>
		osc_on == occ_osc_s'($past(pwdata[2:0])) && !osc_unlocked) else $error("unlocked write");
	AST_OTHER_RELOCKS: assert property (osc_unlocked && wr_other |=> !osc_unlocked)
		else $error("other write left key open");
	AST_XTAL_OFF_CLEARS: assert property (ce && !osc_on.xtal |=> !osc_stable.xtal)
		else $error("xtal flag while off");
	AST_LO_OFF_CLEARS: assert property (ce && !osc_on.lo |=> !osc_stable.lo)
		else $error("slow flag while off");
	AST_XTAL_STICKY: assert property (osc_stable.xtal && osc_on.xtal |=> osc_stable.xtal)
		else $error("xtal flag dropped");
	// eight cycles covers sync plus a filter of up to six cycles
	AST_HI_SETTLES: assert property ((ce && osc_on.hi && osc_ready_raw.hi) [*8]
		|=> osc_stable.hi) else $error("fast flag late");

	// main scenarios reached
	cover property (key_ok);
	cover property (irq);
	cover property ($rose(osc_stable.xtal));
endmodule

bind occ_top occ_top_monitor #(.FILTER_CYCLES(FILTER_CYCLES)) occ_top_monitor_i (
	.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .osc_ready_raw(osc_ready_raw), .osc_on(osc_on),
	.osc_stable(osc_stable), .afe_ctrl_clock_off(afe_ctrl_clock_off),
	.clock_gate_enables(clock_gate_enables), .osc_unlocked(osc_unlocked), .irq(irq));

/* File: verification/tb_top.sv */
/*
 * register-level testbench of occ_top over apb.
 * assumes zero-wait-state answers are not relied on; ce high but for one freeze.
 */
`timescale 1ns/1ps
module tb_top
	import occ_pkg::*;
;
	logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, slverr;
	logic afe_ctrl_clock_off, osc_unlocked, irq;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [15:0] clock_gate_enables;
	occ_osc_s osc_ready_raw, osc_on, osc_stable;
	int fail_count = 0, n_compared = 0, cyc = 0;

	occ_top #(.FILTER_CYCLES(4)) occ_top_i (.pclk(pclk), .presetn(presetn), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.osc_ready_raw(osc_ready_raw), .osc_on(osc_on), .osc_stable(osc_stable),
		.afe_ctrl_clock_off(afe_ctrl_clock_off), .clock_gate_enables(clock_gate_enables),
		.osc_unlocked(osc_unlocked), .irq(irq));

	// 50 MHz clock
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// hang guard, far above the few hundred cycles needed
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			end_sim();
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one apb transfer; ends two edges later so registered outputs settle
	task automatic bus(input logic [31:0] a, input logic [31:0] d, input logic w);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwdata <= d;
		pwrite <= w;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		slverr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		@(posedge pclk);
	endtask

	task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
		bus(a, 32'h0, 1'b0);
		chk(nm, rd, exp);
	endtask

	task automatic end_sim();
		if (fail_count == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		{presetn, ce, psel, penable, pwrite} = 5'h08;
		{paddr, pwdata, pstrb, osc_ready_raw} = 71'h0;
		pstrb = 4'hF;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("osc_on", osc_on, 32'h3);
		rdchk("gate", OCC_OFF_CLK_GATE, 32'h1C0);
		rdchk("key", OCC_OFF_UNLOCK_KEY, 32'h0);
		rdchk("osc", OCC_OFF_OSC_CTRL, 32'h3);
		bus(OCC_OFF_CLK_GATE, 32'h1E9, 1'b1);
		chk("afe", afe_ctrl_clock_off, 32'h1);
		rdchk("gate", OCC_OFF_CLK_GATE, 32'h1E9);
		bus(OCC_OFF_CLK_GATE, 32'hFDC9, 1'b1);
		chk("afe", afe_ctrl_clock_off, 32'h0);
		rdchk("gate", OCC_OFF_CLK_GATE, 32'h1C9);
		// locked write is dropped and raises the rejected event
		bus(OCC_OFF_OSC_CTRL, 32'h7, 1'b1);
		chk("osc_on", osc_on, 32'h3);
		rdchk("status", OCC_OFF_IRQ_STATUS, 32'h8);
		chk("irq", irq, 32'h0);
		bus(OCC_OFF_IRQ_MASK, 32'h8, 1'b1);
		chk("irq", irq, 32'h1);
		bus(OCC_OFF_IRQ_STATUS, 32'h8, 1'b1);
		chk("irq", irq, 32'h0);
		// one unlock admits exactly one control write
		bus(OCC_OFF_UNLOCK_KEY, 32'hCB14, 1'b1);
		chk("unlocked", osc_unlocked, 32'h1);
		bus(OCC_OFF_OSC_CTRL, 32'h7, 1'b1);
		chk("osc_on", osc_on, 32'h7);
		bus(OCC_OFF_OSC_CTRL, 32'h0, 1'b1);
		chk("osc_on", osc_on, 32'h7);
		bus(OCC_OFF_UNLOCK_KEY, 32'hCB14, 1'b1);
		bus(OCC_OFF_CLK_GATE, 32'h1C9, 1'b1);
		chk("unlocked", osc_unlocked, 32'h0);
		bus(OCC_OFF_OSC_CTRL, 32'h0, 1'b1);
		chk("osc_on", osc_on, 32'h7);
		bus(OCC_OFF_UNLOCK_KEY, 32'hCB14, 1'b1);
		bus(32'hA30, 32'h5, 1'b1);
		chk("slverr", slverr, 32'h1);
		chk("unlocked", osc_unlocked, 32'h0);
		// all three settle, then crystal ready drops
		osc_ready_raw <= 3'h7;
		repeat (12) @(posedge pclk);
		rdchk("osc", OCC_OFF_OSC_CTRL, 32'h707);
		bus(OCC_OFF_IRQ_MASK, 32'h7, 1'b1);
		chk("irq", irq, 32'h1);
		bus(OCC_OFF_IRQ_STATUS, 32'h7, 1'b1);
		chk("irq", irq, 32'h0);
		osc_ready_raw <= 3'h3;
		repeat (12) @(posedge pclk);
		rdchk("osc", OCC_OFF_OSC_CTRL, 32'h707);
		bus(OCC_OFF_UNLOCK_KEY, 32'hCB14, 1'b1);
		bus(OCC_OFF_OSC_CTRL, 32'h3, 1'b1);
		rdchk("osc", OCC_OFF_OSC_CTRL, 32'h303);
		osc_ready_raw <= 3'h7;
		bus(OCC_OFF_UNLOCK_KEY, 32'hCB14, 1'b1);
		bus(OCC_OFF_OSC_CTRL, 32'h4, 1'b1);
		repeat (12) @(posedge pclk);
		rdchk("osc", OCC_OFF_OSC_CTRL, 32'h404);
		// both fast enables set ahead of the reset request; ce low freezes the filter
		bus(OCC_OFF_UNLOCK_KEY, 32'hCB14, 1'b1);
		bus(OCC_OFF_OSC_CTRL, 32'h7, 1'b1);
		ce <= 1'b0;
		repeat (12) @(posedge pclk);
		chk("frozen", osc_stable, 32'h4);
		ce <= 1'b1;
		// software polls the fast flag before using that oscillator
		rd = 32'h0;
		while (rd[OCC_HI_OK_BIT] !== 1'b1) begin
			bus(OCC_OFF_OSC_CTRL, 32'h0, 1'b0);
		end
		chk("osc", rd, 32'h707);
		// system reset request, modelled as a reset pulse in mid-run
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("rst_on", osc_on, 32'h3);
		chk("rst_stable", osc_stable, 32'h0);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("rst_gate", clock_gate_enables, 32'h1C0);
		chk("rst_lock", osc_unlocked, 32'h0);
		chk("rst_irq", irq, 32'h0);
		rdchk("rst_osc", OCC_OFF_OSC_CTRL, 32'h3);
		end_sim();
	end
endmodule
